// ---- logic/pcs_defines.svh ----
// Purpose: offsets, field positions, reset values and mmd codes for the pma control/status slice
// Assumes: 16-bit registers, clause 45 style addressing (mmd select + 16-bit register address)
// Notes:   definitions only
`ifndef PCS_DEFINES_SVH
`define PCS_DEFINES_SVH

// ----------------------------------------
// mmd selects
// ----------------------------------------
`define PCS_MMD_PMA          5'b00001
`define PCS_MMD_VENDOR       5'b11110

// ----------------------------------------
// register addresses
// ----------------------------------------
`define PCS_ADDR_CTRL1       16'h0000
`define PCS_ADDR_STAT1       16'h0001
`define PCS_ADDR_STAT2       16'h0008
`define PCS_ADDR_TRIG_LOAD   16'h8100
`define PCS_ADDR_TRIG_ALLOW  16'h8101

// ----------------------------------------
// field positions
// ----------------------------------------
`define PCS_BIT_RESET        15
`define PCS_BIT_LOW_POWER    11
`define PCS_BIT_LOOPBACK     0
`define PCS_BIT_FAULT        7
`define PCS_BIT_RX_LINK      2
`define PCS_BIT_LP_CAPABLE   1
`define PCS_BIT_TRIGGER      2
`define PCS_TRIG_RW_MASK     16'h07FF

// ----------------------------------------
// reset values
// ----------------------------------------
`define PCS_RST_CTRL1        16'h0000
`define PCS_RST_STAT1        16'h0002
`define PCS_RST_TRIG         16'h0000

`endif

// ---- logic/pcs_pkg.sv ----
// Purpose: types shared by the pma control/status slice
// Assumes: management frame already decoded into one access per request
// Notes:   constants live in pcs_defines.svh
package pcs_pkg;

  // one decoded management access
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        cl22;
    logic [4:0]  mmd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } pcs_req_t;

  // answer to an access
  typedef struct packed {
    logic        valid;
    logic        hit;
    logic [15:0] rdata;
  } pcs_rsp_t;

  // controls driven into the datapath
  typedef struct packed {
    logic        global_reset;
    logic        low_power_request;
    logic        hs_loopback;
    logic        tx_preset_load;
  } pcs_ctrl_t;

  typedef enum logic [1:0] {
    PCS_TRIG_IDLE,
    PCS_TRIG_ARMED
  } pcs_trig_t;

endpackage

// ---- logic/pcs_regs.sv ----
// Purpose: pma control/status and tx preset trigger registers reached by station management
// Assumes: the management decoder hands over one access per cycle; cl22 indirect accesses arrive
//          already resolved to a vendor register address
// Notes:   read answer is registered one cycle after the request
`timescale 1ns/1ns
`include "pcs_defines.svh"

// Contract
// - trigger-allow bit 2 must be set before a default tx preset load is allowed.
// - trigger bit 2 is ignored unless the allow bit is high.
// - preset load takes effect only while link training is enabled.
// - pma/pmd registers answer only to clause 45 with mmd select 00001.
// - link-training registers also reachable via clause 22 indirect and mmd 11110.
// - control bit 15 resets datapath and registers like the reset pin; self clears.
// - control bit 11 requests power down; resets to zero.
// - control bit 0 enables high-speed side loopback.
// - status bit 7 reads one while any tx or rx fault is seen.
// - fault bit clears only after status-2 read with no later fault.
// - status bit 1 always reads one, low power capable.
// - reserved bits 15:11 of both trigger registers read zero.
// - trigger registers reset to 0000, status register to 0002.
module pcs_regs (
  // clock and reset
  input  wire logic              core_clk_in,
  input  wire logic              nrst_in,
  // management access
  input  wire pcs_pkg::pcs_req_t req_in,
  output pcs_pkg::pcs_rsp_t      rsp_out,
  // datapath status
  input  wire logic              tx_fault_in,
  input  wire logic              rx_fault_in,
  input  wire logic              rx_link_in,
  input  wire logic              link_training_en_in,
  // datapath controls
  output pcs_pkg::pcs_ctrl_t     ctrl_out
);
  import pcs_pkg::*;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  function automatic logic is_pma(input pcs_req_t r, input logic [15:0] a);
    is_pma = !r.cl22 && (r.mmd == `PCS_MMD_PMA) && (r.addr == a);
  endfunction

  function automatic logic is_vendor(input pcs_req_t r, input logic [15:0] a);
    is_vendor = (r.cl22 || (r.mmd == `PCS_MMD_VENDOR)) && (r.addr == a);
  endfunction

  logic hit_ctrl;
  logic hit_stat1;
  logic hit_stat2;
  logic hit_load;
  logic hit_allow;
  logic wr;
  logic rd;

  assign hit_ctrl  = is_pma(req_in, `PCS_ADDR_CTRL1);
  assign hit_stat1 = is_pma(req_in, `PCS_ADDR_STAT1);
  assign hit_stat2 = is_pma(req_in, `PCS_ADDR_STAT2);
  assign hit_load  = is_vendor(req_in, `PCS_ADDR_TRIG_LOAD);
  assign hit_allow = is_vendor(req_in, `PCS_ADDR_TRIG_ALLOW);
  assign wr        = req_in.valid && req_in.write;
  assign rd        = req_in.valid && !req_in.write;

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic      soft_rst_q;
  logic      soft_rst_d;
  logic      low_power_q;
  logic      low_power_d;
  logic      loopback_q;
  logic      loopback_d;
  logic [10:0] load_q;
  logic [10:0] load_d;
  logic [10:0] allow_q;
  logic [10:0] allow_d;
  logic      fault_q;
  logic      fault_d;
  logic      fault_seen_q;
  logic      fault_seen_d;
  logic      link_q;
  logic      link_d;
  pcs_trig_t trig_q;
  pcs_trig_t trig_d;
  logic      preset_q;
  logic      preset_d;
  pcs_rsp_t  rsp_q;
  pcs_rsp_t  rsp_d;
  logic [15:0] stat1_val;
  logic      any_fault;

  assign any_fault = tx_fault_in || rx_fault_in;
  assign stat1_val = {8'h00, fault_q, 4'h0, link_q, 1'b1, 1'b0};

  // ----------------------------------------
  // read views
  // ----------------------------------------
  // trigger registers store bits 10:0 only, so the top five can never read back as one
  function automatic logic [15:0] trig_view(input logic [10:0] v);
    trig_view = {5'h00, v};
  endfunction

  // the reset bit is never stored, so it reads zero once its pulse is over
  function automatic logic [15:0] ctrl_view(input logic lp, input logic lb);
    ctrl_view = {4'h0, lp, 10'h000, lb};
  endfunction

  // ----------------------------------------
  // control register
  // ----------------------------------------
  // the reset pulse clears its own flop, so it stands for exactly one cycle
  always_comb begin
    soft_rst_d  = 1'b0; // self clearing
    low_power_d = low_power_q;
    loopback_d  = loopback_q;
    if (soft_rst_q) begin
      low_power_d = 1'b0;
      loopback_d  = 1'b0;
    end else if (wr && hit_ctrl) begin
      soft_rst_d  = req_in.wdata[`PCS_BIT_RESET];
      low_power_d = req_in.wdata[`PCS_BIT_LOW_POWER];
      loopback_d  = req_in.wdata[`PCS_BIT_LOOPBACK];
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      soft_rst_q  <= 1'b0;
      low_power_q <= 1'b0;
      loopback_q  <= 1'b0;
    end else begin
      soft_rst_q  <= soft_rst_d;
      low_power_q <= low_power_d;
      loopback_q  <= loopback_d;
    end
  end

  // ----------------------------------------
  // trigger registers
  // ----------------------------------------
  always_comb begin
    load_d  = load_q;
    allow_d = allow_q;
    if (soft_rst_q) begin
      load_d  = 11'h000;
      allow_d = 11'h000;
    end else begin
      if (wr && hit_load) begin
        load_d = req_in.wdata[10:0];
      end
      if (wr && hit_allow) begin
        allow_d = req_in.wdata[10:0];
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      load_q  <= 11'h000;
      allow_q <= 11'h000;
    end else begin
      load_q  <= load_d;
      allow_q <= allow_d;
    end
  end

  // ----------------------------------------
  // preset trigger sequencer
  // ----------------------------------------
  // arms as soon as the trigger is high while loading is allowed, fires on the
  // write that lowers it; a trigger that simply stays low never fires again
  always_comb begin
    trig_d   = trig_q;
    preset_d = 1'b0;
    if (soft_rst_q) begin
      trig_d = PCS_TRIG_IDLE;
    end else begin
      unique case (trig_q)
        PCS_TRIG_IDLE: begin
          if (load_d[`PCS_BIT_TRIGGER] && allow_q[`PCS_BIT_TRIGGER]) begin
            trig_d = PCS_TRIG_ARMED;
          end
        end
        PCS_TRIG_ARMED: begin
          if (!load_d[`PCS_BIT_TRIGGER]) begin
            trig_d   = PCS_TRIG_IDLE;
            preset_d = allow_q[`PCS_BIT_TRIGGER] && link_training_en_in;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      trig_q   <= PCS_TRIG_IDLE;
      preset_q <= 1'b0;
    end else begin
      trig_q   <= trig_d;
      preset_q <= preset_d;
    end
  end

  // ----------------------------------------
  // fault summary
  // ----------------------------------------
  // a fault in the same cycle as the status-2 read wins, so no fault is ever lost
  always_comb begin
    fault_d      = fault_q;
    fault_seen_d = fault_seen_q;
    if (soft_rst_q) begin
      fault_d      = 1'b0;
      fault_seen_d = 1'b0;
    end else begin
      if (rd && hit_stat2) begin
        fault_seen_d = 1'b0;
      end
      if (any_fault) begin
        fault_d      = 1'b1;
        fault_seen_d = 1'b1;
      end else if (fault_q && !fault_seen_q) begin
        fault_d = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fault_q      <= 1'b0;
      fault_seen_q <= 1'b0;
    end else begin
      fault_q      <= fault_d;
      fault_seen_q <= fault_seen_d;
    end
  end

  // ----------------------------------------
  // receive link, latching low
  // ----------------------------------------
  // a read reloads the live level, yet a drop in the read cycle itself still latches
  always_comb begin
    link_d = link_q;
    if (soft_rst_q) begin
      link_d = 1'b0;
    end else if (rd && hit_stat1) begin
      link_d = rx_link_in;
    end else if (!rx_link_in) begin
      link_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      link_q <= 1'b0;
    end else begin
      link_q <= link_d;
    end
  end

  // ----------------------------------------
  // read answer
  // ----------------------------------------
  // a request landing in the soft reset cycle is dropped, as with the pin held low
  always_comb begin
    rsp_d = '0;
    if (!soft_rst_q) begin
      rsp_d.valid = req_in.valid;
      rsp_d.hit   = hit_ctrl || hit_stat1 || hit_stat2 || hit_load || hit_allow;
      if (rd) begin
        if (hit_ctrl) begin
          rsp_d.rdata = ctrl_view(low_power_q, loopback_q);
        end else if (hit_stat1) begin
          rsp_d.rdata = stat1_val;
        end else if (hit_load) begin
          rsp_d.rdata = trig_view(load_q);
        end else if (hit_allow) begin
          rsp_d.rdata = trig_view(allow_q);
        end
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= rsp_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign rsp_out                    = rsp_q;
  assign ctrl_out.global_reset      = soft_rst_q;
  assign ctrl_out.low_power_request = low_power_q;
  assign ctrl_out.hs_loopback       = loopback_q;
  assign ctrl_out.tx_preset_load    = preset_q;

endmodule

// ---- verification/pcs_host_model.sv ----
// Purpose: station management host issuing decoded accesses
// Assumes: one access in flight, answer one cycle after take
// Notes:   released request lines show inverted values, never stale ones
`timescale 1ns/1ns
module pcs_host_model (
  // clock
  input  wire logic              clk_in,
  // access
  output pcs_pkg::pcs_req_t      req_out,
  input  wire pcs_pkg::pcs_rsp_t rsp_in
);
  import pcs_pkg::*;
  initial req_out = '0;
  task automatic acc(input logic w, c22, input logic [4:0] m, input logic [15:0] a, d, output pcs_rsp_t r);
    @(posedge clk_in);
    req_out <= {1'b1, w, c22, m, a, d};
    @(posedge clk_in);
    req_out <= ~req_out;
    @(posedge clk_in);
    r = rsp_in;
  endtask
  // trigger must go high then back low to load once
  task automatic preset(output pcs_rsp_t r);
    acc(1, 0, 5'h1e, 16'h8100, 16'h0004, r);
    acc(1, 0, 5'h1e, 16'h8100, 16'h0000, r);
  endtask
endmodule

// ---- verification/pcs_regs_checker.sv ----
// Purpose: port assertions for pcs_regs
// Assumes: one clock, async active-low reset
// Notes:   bound to every pcs_regs instance
`timescale 1ns/1ns
module pcs_regs_checker (
  input wire logic               core_clk_in,
  input wire logic               nrst_in,
  input wire pcs_pkg::pcs_req_t  req_in,
  input wire pcs_pkg::pcs_rsp_t  rsp_out,
  input wire logic               tx_fault_in,
  input wire logic               rx_fault_in,
  input wire logic               rx_link_in,
  input wire logic               link_training_en_in,
  input wire pcs_pkg::pcs_ctrl_t ctrl_out
);
  import pcs_pkg::*;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  logic pma;
  logic ven;
  logic rd;
  logic c1w;
  assign pma = req_in.valid && !req_in.cl22 && req_in.mmd == 5'h01;
  assign ven = req_in.valid && (req_in.cl22 || req_in.mmd == 5'h1e);
  assign rd = req_in.valid && !req_in.write;
  assign c1w = pma && req_in.write && req_in.addr == 16'h0000 && !ctrl_out.global_reset;
  a_rsp_follows: assert property (req_in.valid && !ctrl_out.global_reset |=> rsp_out.valid)
    else $error("no answer after request");
  a_rsp_no_extra: assert property (!req_in.valid |=> !rsp_out.valid) else $error("answer without request");
  a_pma_refuse: assert property (req_in.valid && req_in.addr[15:4] == 12'h000 && !pma |=> !rsp_out.hit)
    else $error("pma register hit on wrong select");
  a_trig_refuse: assert property (req_in.valid && req_in.addr[15:1] == 15'h4080 && !ven |=> !rsp_out.hit)
    else $error("trigger register hit on wrong select");
  a_rsvd_zero: assert property (rd && req_in.addr[15:8] == 8'h81 |=> rsp_out.rdata[15:11] == 5'h00)
    else $error("reserved trigger bits not zero");
  a_lp_capable: assert property (rd && pma && req_in.addr == 16'h0001 && !ctrl_out.global_reset
    |=> rsp_out.hit && rsp_out.rdata[1]) else $error("low power capable bit not set");
  a_fault_shown: assert property (rd && pma && req_in.addr == 16'h0001 && $past(nrst_in)
    && !ctrl_out.global_reset && !$past(ctrl_out.global_reset)
    && $past(tx_fault_in || rx_fault_in) |=> rsp_out.rdata[7]) else $error("fault not reported");
  a_soft_reset: assert property (c1w && req_in.wdata[15] |=> ctrl_out.global_reset ##1 !ctrl_out.global_reset)
    else $error("soft reset pulse wrong");
  a_ctrl_levels: assert property (c1w && !req_in.wdata[15] |=>
    ctrl_out.low_power_request == $past(req_in.wdata[11]) && ctrl_out.hs_loopback == $past(req_in.wdata[0]))
    else $error("control levels wrong");
  a_preset_gate: assert property ($rose(ctrl_out.tx_preset_load) |-> $past(link_training_en_in))
    else $error("preset load without training");
  a_preset_once: assert property (ctrl_out.tx_preset_load |=> !ctrl_out.tx_preset_load)
    else $error("preset load longer than a pulse");
  c_preset: cover property (ctrl_out.tx_preset_load);
  c_soft: cover property (ctrl_out.global_reset);
  c_hit: cover property (rsp_out.valid && rsp_out.hit);
endmodule
bind pcs_regs pcs_regs_checker i_pcs_regs_checker (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
  .req_in(req_in), .rsp_out(rsp_out), .tx_fault_in(tx_fault_in), .rx_fault_in(rx_fault_in),
  .rx_link_in(rx_link_in), .link_training_en_in(link_training_en_in), .ctrl_out(ctrl_out));

// ---- verification/pcs_regs_tb.sv ----
// Purpose: self-checking bench for pcs_regs
// Assumes: host model issues one access at a time
// Notes:   random write data from seed 8
`timescale 1ns/1ns
module pcs_regs_tb;
  import pcs_pkg::*;
  logic clk = 0, nrst = 0, txf = 0, rxf = 0, lnk = 0, lt = 0;
  pcs_req_t req;
  pcs_rsp_t rsp;
  pcs_ctrl_t ctl;
  pcs_rsp_t r;
  int bad_count = 0, cmp_count = 0, seed = 8, np = 0, ng = 0, e;
  logic [15:0] d;
  logic [15:0] tv [2] = '{16'h0000, 16'h0000};
  initial forever #4 clk = ~clk;
  always @(posedge clk) np <= np + ctl.tx_preset_load;
  always @(posedge clk) ng <= ng + ctl.global_reset;
  pcs_regs i_pcs_regs (.core_clk_in(clk), .nrst_in(nrst), .req_in(req), .rsp_out(rsp), .tx_fault_in(txf),
    .rx_fault_in(rxf), .rx_link_in(lnk), .link_training_en_in(lt), .ctrl_out(ctl));
  pcs_host_model i_pcs_host_model (.clk_in(clk), .req_out(req), .rsp_in(rsp));
  task automatic chk(input string n, input logic [15:0] x, g);
    cmp_count++;
    if (g !== x) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask
  function automatic logic [15:0] st1(input logic f, l);
    return {8'h00, f, 4'h0, l, 2'b10};
  endfunction
  task automatic ac(input logic w, c22, input logic [4:0] m, input logic [15:0] a, dd);
    i_pcs_host_model.acc(w, c22, m, a, dd, r);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge clk);
    bad_count++;
    give_verdict;
  end
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1;
    lnk <= 1;
    ac(0, 0, 1, 16'h0001, 0); chk("stat1", st1(0, 0), r.rdata);
    ac(0, 0, 1, 16'h0001, 0); chk("stat1", st1(0, 1), r.rdata);
    for (int i = 0; i < 8; i++) begin
      e = 16'h8100 + i % 2;
      ac(0, i[1], i[1] ? 5'h00 : 5'h1e, e[15:0], 0); chk("trig", tv[i%2], r.rdata);
      d = 16'($random(seed));
      ac(1, i[2], 5'h1e, e[15:0], d);
      tv[i%2] = d & 16'h07ff;
    end
    ac(0, 1, 5'h01, 16'h0000, 0); chk("hit", 0, r.hit);
    ac(0, 0, 5'h1e, 16'h0001, 0); chk("hit", 0, r.hit);
    ac(0, 0, 5'h01, 16'h8100, 0); chk("hit", 0, r.hit);
    for (int i = 0; i < 4; i++) begin
      lt <= i[1];
      ac(1, 0, 5'h1e, 16'h8101, {13'h0000, i[0], 2'b00});
      e = np;
      i_pcs_host_model.preset(r);
      repeat (3) @(posedge clk);
      chk("preset", i[0] & i[1], np - e);
    end
    d = 16'($random(seed)) & 16'h7fff;
    ac(1, 0, 1, 0, d); chk("ctrl", {d[11], d[0]}, {ctl.low_power_request, ctl.hs_loopback});
    ac(0, 0, 1, 0, 0); chk("ctrl1", d & 16'h0801, r.rdata);
    for (int i = 0; i < 2; i++) begin
      txf <= !i;
      rxf <= i;
      ac(0, 0, 1, 16'h0008, 0);
      txf <= 0;
      rxf <= 0;
      ac(0, 0, 1, 1, 0); chk("stat1", st1(1, 1), r.rdata);
      ac(0, 0, 1, 16'h0008, 0); chk("hit", 1, r.hit);
      ac(0, 0, 1, 1, 0); chk("stat1", st1(0, 1), r.rdata);
    end
    ac(0, 0, 1, 16'h0008, 0);
    rxf <= 1;
    @(posedge clk) rxf <= 0;
    ac(0, 0, 1, 1, 0); chk("stat1", st1(1, 1), r.rdata);
    ac(0, 0, 1, 16'h0008, 0);
    ac(0, 0, 1, 1, 0); chk("stat1", st1(0, 1), r.rdata);
    @(posedge clk) lnk <= 0;
    @(posedge clk) lnk <= 1;
    ac(0, 0, 1, 1, 0); chk("stat1", st1(0, 0), r.rdata);
    ac(0, 0, 1, 1, 0); chk("stat1", st1(0, 1), r.rdata);
    e = ng;
    ac(1, 0, 1, 0, 16'h8801); chk("rsp", 1, r.valid);
    ac(0, 0, 1, 0, 0); chk("ctrl1", 0, r.rdata);
    chk("greset", 1, ng - e);
    ac(0, 0, 5'h1e, 16'h8101, 0); chk("trig", 0, r.rdata);
    give_verdict;
  end
endmodule
